// file: cprd_pkg.sv
`default_nettype none
// ==========================================================
// Shared constants for the core clock ratio decoder
package cprd_pkg;
	// Field layout, numbered with bit 0 as the most significant
	localparam int CPRD_FIELD_W   = 7;
	localparam int CPRD_DIV_MSB   = 0;
	localparam int CPRD_DIV_LSB   = 1;
	localparam int CPRD_RATIO_MSB = 2;
	localparam int CPRD_RATIO_LSB = 5;
	localparam int CPRD_HALF_BIT  = 6;

	// Ratio selector encodings
	localparam logic [3:0] CPRD_SEL_BYPASS = 4'h0;
	localparam logic [3:0] CPRD_SEL_ONE    = 4'h1;
	localparam logic [3:0] CPRD_SEL_TWO    = 4'h2;
	localparam logic [3:0] CPRD_SEL_THREE  = 4'h3;

	// Divider selector encodings and factors
	localparam logic [1:0] CPRD_DSEL_2 = 2'h0;
	localparam logic [1:0] CPRD_DSEL_4 = 2'h1;
	localparam logic [3:0] CPRD_DIV_2  = 4'h2;
	localparam logic [3:0] CPRD_DIV_4  = 4'h4;
	localparam logic [3:0] CPRD_DIV_8  = 4'h8;

	// Ratio is carried doubled so that 1.5 and 2.5 stay whole
	localparam int CPRD_RATIO_W = 3;
	localparam int CPRD_VCO_W   = 6;

	// Reset values of the held outputs
	localparam logic                    CPRD_RST_BYPASS = 1'h1;
	localparam logic [CPRD_RATIO_W-1:0] CPRD_RST_RATIO  = 3'h0;
	localparam logic [3:0]              CPRD_RST_DIV    = 4'h0;
	localparam logic [CPRD_VCO_W-1:0]   CPRD_RST_VCO    = 6'h00;

	// Capture sequence
	typedef enum logic {
		CPRD_ST_WAIT = 1'b0,
		CPRD_ST_HELD = 1'b1
	} cprd_state_t;
endpackage : cprd_pkg
`default_nettype wire

// file: cprd_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Field in, decoded selections out
interface cprd_dec_if;
	import cprd_pkg::*;
	logic [0:CPRD_FIELD_W-1] field;
	logic                    bypass;
	logic                    reserved;
	logic [CPRD_RATIO_W-1:0] ratio_x2;
	logic [3:0]              vco_div;
	logic [CPRD_VCO_W-1:0]   vco_x2;
	modport user (output field, input bypass, reserved, ratio_x2, vco_div, vco_x2);
	modport dec  (input field, output bypass, reserved, ratio_x2, vco_div, vco_x2);
endinterface : cprd_dec_if
`default_nettype wire

// file: cprd_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Combinational decode of the core clock configuration field
module cprd_decode (
	cprd_dec_if.dec dec
);
	import cprd_pkg::*;

	// Divider factor from the two divider bits
	function automatic logic [3:0] cprd_div_of(input logic [1:0] sel);
		cprd_div_of = (sel == CPRD_DSEL_2) ? CPRD_DIV_2 :
		              (sel == CPRD_DSEL_4) ? CPRD_DIV_4 : CPRD_DIV_8;
	endfunction : cprd_div_of

	wire logic [3:0] ratio_sel;
	wire logic [1:0] div_sel;
	wire logic       half;
	wire logic [3:0] div_raw;
	wire logic       legal;

	// Field slices
	assign ratio_sel = dec.field[CPRD_RATIO_MSB:CPRD_RATIO_LSB];
	assign div_sel   = dec.field[CPRD_DIV_MSB:CPRD_DIV_LSB];
	assign half      = dec.field[CPRD_HALF_BIT];
	assign div_raw   = cprd_div_of(div_sel);

	// Selector three has no half step; anything above three is unlisted
	assign legal = (ratio_sel == CPRD_SEL_BYPASS) || (ratio_sel == CPRD_SEL_ONE) ||
	               (ratio_sel == CPRD_SEL_TWO) || ((ratio_sel == CPRD_SEL_THREE) && !half);
	assign dec.reserved = !legal; // [R4]

	// Bypass ignores divider and half bits; reserved also falls back to bypass
	assign dec.bypass   = (ratio_sel == CPRD_SEL_BYPASS) || !legal; // [R2]
	assign dec.ratio_x2 = dec.bypass ? CPRD_RST_RATIO :
	                      CPRD_RATIO_W'({ratio_sel[1:0], 1'b0} + {2'h0, half}); // [R3]
	assign dec.vco_div  = dec.bypass ? CPRD_RST_DIV : div_raw; // [R5]
	// Vco as a doubled multiple of the bus clock: ratio times divider
	assign dec.vco_x2   = dec.bypass ? CPRD_RST_VCO :
	                      CPRD_VCO_W'(dec.ratio_x2 * div_raw); // [R6]
endmodule : cprd_decode
`default_nettype wire

// file: core_pll_ratio_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Core clock ratio and VCO divider selection, held from reset

// Overview of operation
// [R1] Seven-bit field sets core to bus ratio
// [R2] Selector 0000 bypasses PLL, other bits ignored
// [R3] Selectors 1..3 with half bit give ratios
// [R4] Source never supplies unlisted field values
// [R5] Bits 0-1 choose divide 2, 4, 8
// [R6] VCO equals core clock times divider
// [R7] Source keeps VCO within 500 to 800 MHz
// [R8] Field captured once at reset, then held
module core_pll_ratio_decode (
	// Clock and reset
	input  wire logic                              i_clk_sys,
	input  wire logic                              i_nrst,
	// Configuration word input
	input  wire logic [0:cprd_pkg::CPRD_FIELD_W-1] i_core_pll_config_field,
	// Held selections
	output logic                                   o_cfg_valid,
	output logic                                   o_pll_bypass,
	output logic                                   o_cfg_reserved,
	output logic [cprd_pkg::CPRD_RATIO_W-1:0]      o_ratio_x2,
	output logic [3:0]                             o_vco_div,
	output logic [cprd_pkg::CPRD_VCO_W-1:0]        o_vco_x2
);
	import cprd_pkg::*;

	cprd_state_t state;
	cprd_state_t next_state;
	wire logic   capture;

	cprd_dec_if dif ();

	// ==========================================================
	// Decode
	assign dif.field = i_core_pll_config_field; // [R1]

	cprd_decode u_decode (
		.dec (dif)
	);

	// ==========================================================
	// Capture sequence: a strap is only sampled after reset release
	assign capture    = (state == CPRD_ST_WAIT);
	assign next_state = capture ? CPRD_ST_HELD : state;

	// State holds once captured until the next reset
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			state <= CPRD_ST_WAIT;
		end else begin
			case (state)
				CPRD_ST_WAIT: state <= next_state;
				CPRD_ST_HELD: state <= CPRD_ST_HELD;
				default:      state <= CPRD_ST_WAIT;
			endcase
		end
	end

	// Held outputs; bypass is the safe value before capture
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_pll_bypass   <= CPRD_RST_BYPASS;
			o_cfg_reserved <= 1'b0;
			o_ratio_x2     <= CPRD_RST_RATIO;
			o_vco_div      <= CPRD_RST_DIV;
			o_vco_x2       <= CPRD_RST_VCO;
		end else if (capture) begin // [R8]
			o_pll_bypass   <= dif.bypass;
			o_cfg_reserved <= dif.reserved;
			o_ratio_x2     <= dif.ratio_x2;
			o_vco_div      <= dif.vco_div;
			o_vco_x2       <= dif.vco_x2;
		end
	end

	assign o_cfg_valid = (state == CPRD_ST_HELD);

	// ==========================================================
	// Checks
	wire logic [3:0] in_sel;
	wire logic [1:0] in_dsel;
	assign in_sel  = i_core_pll_config_field[CPRD_RATIO_MSB:CPRD_RATIO_LSB];
	assign in_dsel = i_core_pll_config_field[CPRD_DIV_MSB:CPRD_DIV_LSB];
	wire logic       in_half;
	wire logic       in_unlisted;
	wire logic       cap_edge;
	assign in_half     = i_core_pll_config_field[CPRD_HALF_BIT];
	assign in_unlisted = (in_sel > CPRD_SEL_THREE) || ((in_sel == CPRD_SEL_THREE) && in_half);
	// Capture stays high all through reset, so a check may only start where reset was already gone
	// at the sampling edge; otherwise the release edge itself would pass for a capture
	assign cap_edge    = capture && i_nrst;

	// Expected divider factor, kept apart from the decoder's own function
	function automatic logic [3:0] cprd_exp_div(input logic [1:0] dsel);
		case (dsel)
			CPRD_DSEL_2: cprd_exp_div = CPRD_DIV_2;
			CPRD_DSEL_4: cprd_exp_div = CPRD_DIV_4;
			default:     cprd_exp_div = CPRD_DIV_8;
		endcase
	endfunction : cprd_exp_div

	// Expected doubled ratio: two per whole step, one more for the half bit
	function automatic logic [CPRD_RATIO_W-1:0] cprd_exp_ratio(input logic [3:0] sel, input logic half);
		cprd_exp_ratio = CPRD_RATIO_W'(sel + sel + {3'h0, half});
	endfunction : cprd_exp_ratio

	// A capture of a listed value, and of one the source should never strap
	sequence s_take_listed;
		cap_edge && !in_unlisted;
	endsequence

	sequence s_take_unlisted;
		cap_edge && in_unlisted;
	endsequence

	// Two held cycles back to back
	sequence s_held_pair;
		o_cfg_valid ##1 o_cfg_valid;
	endsequence

	sequence s_capture;
		cap_edge ##1 o_cfg_valid;
	endsequence

	a_valid_after_one: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R8]
		cap_edge |=> o_cfg_valid)
		else $error("valid not raised after capture");

	a_held_stable: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R8]
		o_cfg_valid ##1 o_cfg_valid |-> $stable(o_ratio_x2) && $stable(o_vco_div) && $stable(o_pll_bypass))
		else $error("held selection changed");

	a_bypass_sel: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R2]
		cap_edge && in_sel == CPRD_SEL_BYPASS |=> o_pll_bypass && o_ratio_x2 == CPRD_RST_RATIO)
		else $error("zero selector did not bypass");

	a_ratio_map: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R3]
		cap_edge && in_sel == CPRD_SEL_TWO |=>
		!o_pll_bypass && o_ratio_x2 == (3'h4 + {2'h0, $past(i_core_pll_config_field[CPRD_HALF_BIT])}))
		else $error("ratio for selector two wrong");

	a_three_half: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R4]
		cap_edge && in_sel == CPRD_SEL_THREE && i_core_pll_config_field[CPRD_HALF_BIT] |=>
		o_cfg_reserved && o_pll_bypass)
		else $error("unlisted value not flagged");

	a_div_map: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R5]
		cap_edge && in_sel == CPRD_SEL_ONE |=>
		o_vco_div == (($past(in_dsel) == 2'h0) ? 4'h2 : ($past(in_dsel) == 2'h1) ? 4'h4 : 4'h8))
		else $error("divider factor wrong");

	a_vco_product: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R6]
		s_capture |-> o_pll_bypass || (o_vco_x2 == CPRD_VCO_W'(o_ratio_x2 * o_vco_div)))
		else $error("vco multiple mismatch");

	a_field_used: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R1]
		cap_edge && in_sel == CPRD_SEL_ONE && !i_core_pll_config_field[CPRD_HALF_BIT] |=>
		o_ratio_x2 == 3'h2 ##1 o_ratio_x2 == 3'h2)
		else $error("one to one ratio not held");

	// ==========================================================
	// Further checks on the capture and the held selections

	// Before the capture the core must sit on the bus clock, never on a half-set PLL
	a_safe_before_cap: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R8]
		!o_cfg_valid |-> o_pll_bypass && !o_cfg_reserved &&
		o_ratio_x2 == CPRD_RST_RATIO && o_vco_div == CPRD_RST_DIV)
		else $error("outputs not safe before capture");

	a_valid_stays: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R8]
		o_cfg_valid |=> o_cfg_valid)
		else $error("valid dropped without reset");

	a_held_rest: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R8]
		s_held_pair |-> $stable(o_cfg_reserved) && $stable(o_vco_x2))
		else $error("held flag or vco changed");

	// Listed values must never be mistaken for reserved ones
	a_listed_clean: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R3]
		s_take_listed |=> o_cfg_valid && !o_cfg_reserved)
		else $error("listed value flagged reserved");

	// Unlisted values fall back to bypass so the PLL never starts on a guess
	a_unlisted_safe: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R4]
		s_take_unlisted |=> o_cfg_reserved && o_pll_bypass &&
		o_vco_div == CPRD_RST_DIV && o_vco_x2 == CPRD_RST_VCO)
		else $error("unlisted value not made safe");

	a_bypass_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R2]
		cap_edge && in_sel == CPRD_SEL_BYPASS |=>
		!o_cfg_reserved && o_vco_div == CPRD_RST_DIV && o_vco_x2 == CPRD_RST_VCO)
		else $error("bypass did not ignore other bits");

	a_ratio_one: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R3]
		cap_edge && in_sel == CPRD_SEL_ONE |=>
		!o_pll_bypass && o_ratio_x2 == cprd_exp_ratio(CPRD_SEL_ONE, $past(in_half)))
		else $error("ratio for selector one wrong");

	a_ratio_three: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R3]
		cap_edge && in_sel == CPRD_SEL_THREE && !in_half |=>
		!o_pll_bypass && o_ratio_x2 == cprd_exp_ratio(CPRD_SEL_THREE, 1'b0))
		else $error("ratio for selector three wrong");

	a_div_two: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R5]
		cap_edge && in_sel == CPRD_SEL_TWO |=> o_vco_div == cprd_exp_div($past(in_dsel)))
		else $error("divider wrong for selector two");

	a_div_three: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R5]
		cap_edge && in_sel == CPRD_SEL_THREE && !in_half |=> o_vco_div == cprd_exp_div($past(in_dsel)))
		else $error("divider wrong for selector three");

	// Vco multiple rebuilt from the captured field, not from the other outputs
	a_vco_listed: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R6]
		cap_edge && !in_unlisted && in_sel != CPRD_SEL_BYPASS |=>
		o_vco_x2 == CPRD_VCO_W'(cprd_exp_ratio($past(in_sel), $past(in_half)) * cprd_exp_div($past(in_dsel))))
		else $error("vco multiple not ratio times divider");

	a_div_factor: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R5]
		o_cfg_valid && !o_pll_bypass |->
		o_vco_div == CPRD_DIV_2 || o_vco_div == CPRD_DIV_4 || o_vco_div == CPRD_DIV_8)
		else $error("divider outside two four eight");

	a_bypass_zero: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // [R2]
		o_cfg_valid && o_pll_bypass |-> o_ratio_x2 == CPRD_RST_RATIO && o_vco_x2 == CPRD_RST_VCO)
		else $error("bypass left a ratio or vco set");
endmodule : core_pll_ratio_decode
`default_nettype wire

// file: test_core_pll_ratio_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench: every field value captured after a reset, then disturbed
module test_core_pll_ratio_decode;
	import cprd_pkg::*;
	logic                    i_clk_sys;
	logic                    i_nrst;
	logic [0:CPRD_FIELD_W-1] i_core_pll_config_field;
	logic                    o_cfg_valid;
	logic                    o_pll_bypass;
	logic                    o_cfg_reserved;
	logic [CPRD_RATIO_W-1:0] o_ratio_x2;
	logic [3:0]              o_vco_div;
	logic [CPRD_VCO_W-1:0]   o_vco_x2;
	int                      err_total;
	int                      compares;
	logic [31:0]             rng;
	logic [15:0]             got_v;
	logic [15:0]             exp_q [$];
	int                      n_src_ok;

	core_pll_ratio_decode core_pll_ratio_decode_inst (
		.i_clk_sys              (i_clk_sys),
		.i_nrst                 (i_nrst),
		.i_core_pll_config_field(i_core_pll_config_field),
		.o_cfg_valid            (o_cfg_valid),
		.o_pll_bypass           (o_pll_bypass),
		.o_cfg_reserved         (o_cfg_reserved),
		.o_ratio_x2             (o_ratio_x2),
		.o_vco_div              (o_vco_div),
		.o_vco_x2               (o_vco_x2)
	);

	// All outputs packed so one compare covers the whole answer
	assign got_v = {o_cfg_valid, o_pll_bypass, o_cfg_reserved, o_ratio_x2, o_vco_div, o_vco_x2};

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xorshift

	// Index 0 of the field is the value's MSB, so divider sits in the top two bits
	function automatic logic [15:0] model(input int v);
		int d, s, h, r, k, m;
		d = (v >> 5) & 3;
		s = (v >> 1) & 15;
		h = v & 1;
		if (s == 0) return 16'hc000;
		if (s > 3 || (s == 3 && h == 1)) return 16'he000;
		r = 2 * s + h;
		k = (d == 0) ? 2 : (d == 1) ? 4 : 8;
		m = r * k;
		return {3'h4, r[2:0], k[3:0], m[5:0]};
	endfunction : model

	// Fields a careful source may strap: listed, and VCO in range at this 40 MHz bus clock
	function automatic bit src_ok(input int v);
		int d, s, h, vco;
		d = (v >> 5) & 3;
		s = (v >> 1) & 15;
		h = v & 1;
		if (s == 0) return 1'b1;
		if (s > 3 || (s == 3 && h == 1)) return 1'b0;
		vco = (2 * s + h) * ((d == 0) ? 2 : (d == 1) ? 4 : 8) * 20;
		return (vco >= 500) && (vco <= 800);
	endfunction : src_ok

	task automatic chk(input logic [15:0] exp_v);
		compares++;
		if (got_v !== exp_v) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
		end
	endtask : chk

	task automatic print_verdict();
		$display("Compares %0d, mismatches %0d, source-legal fields %0d", compares, err_total, n_src_ok);
		if (err_total == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	// ==========================================================
	// Clock, 25 ns period
	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end

	// Watchdog: the sweep needs about 1000 cycles
	initial begin
		repeat (3000) @(posedge i_clk_sys);
		err_total++;
		print_verdict();
	end

	// ==========================================================
	// Main sequence: a fresh reset per value also exercises mid-run resets
	// Unlisted fields are strapped on purpose to probe the safe fallback; out-of-range listed fields decode as usual
	initial begin
		i_nrst = 1'b0;
		i_core_pll_config_field = '0;
		err_total = 0;
		compares = 0;
		n_src_ok = 0;
		rng = 32'h38;
		for (int v = 0; v < 128; v++) begin
			@(posedge i_clk_sys);
			i_nrst <= 1'b0;
			i_core_pll_config_field <= v[6:0];
			exp_q.push_back(model(v));
			if (src_ok(v)) begin
				n_src_ok++;
			end
			@(posedge i_clk_sys);
			@(negedge i_clk_sys);
			chk(16'h4000);
			@(posedge i_clk_sys);
			i_nrst <= 1'b1;
			@(posedge i_clk_sys);
			@(negedge i_clk_sys);
			chk(exp_q[0]);
			// Disturb the field after capture; nothing may move
			rng = xorshift(rng);
			@(posedge i_clk_sys);
			i_core_pll_config_field <= rng[6:0];
			repeat (3) @(posedge i_clk_sys);
			@(negedge i_clk_sys);
			chk(exp_q.pop_front());
		end
		$display("Test field sweep with capture hold done");
		print_verdict();
	end
endmodule : test_core_pll_ratio_decode
`default_nettype wire
